/* File: hw/pmsp_map.svh */
`ifndef PMSP_MAP_SVH
`define PMSP_MAP_SVH
// Clock periods in ns
`define PMSP_REF_CLK_NS 25
`define PMSP_LINK_CLK_NS 80
`define PMSP_MII_CLK_NS 400
// Link clocks per 2.5 MHz receive clock, and high phase length
`define PMSP_LINK_DIV (`PMSP_MII_CLK_NS / `PMSP_LINK_CLK_NS)
`define PMSP_LINK_HIGH (`PMSP_LINK_DIV / 2)
// System clocks per half period of the MAC-made transmit clock
`define PMSP_MAC_HALF (`PMSP_MII_CLK_NS / (2 * `PMSP_REF_CLK_NS))
// Count values at which the MAC changes its control line
`define PMSP_MAC_ER_AT (`PMSP_MAC_HALF / 2)
`define PMSP_MAC_EN_AT (`PMSP_MAC_HALF + `PMSP_MAC_HALF / 2)
// Reset value of the shared pin synchroniser (pulled up)
`define PMSP_PD_IDLE 1'h1
// Mode held while the link domain settles (RMII slave: no clock pin driven)
`define PMSP_MODE_IDLE 2'h3
`endif

/* File: hw/pmsp_pkg.sv */
package pmsp_pkg;
   // MAC interface modes
   typedef enum logic [1:0] {
      PMSP_MII = 2'h0,
      PMSP_RMII_MST = 2'h1,
      PMSP_RMII_SLV = 2'h3,
      PMSP_RGMII = 2'h2
   } pmsp_mode_e;
endpackage

/* File: hw/pmsp_link_if.sv */
`timescale 1ns/1ps
interface pmsp_link_if;
   // Receive side, driven by the PHY
   logic phy_rx_clk_o;
   logic phy_rx_clk_oe_n;
   logic rx_clk;
   logic phy_rx_ctl;
   logic phy_rx_er;
   // Transmit clock, either end may drive it
   logic phy_tx_clk_o;
   logic phy_tx_clk_oe_n;
   logic mac_tx_clk_o;
   logic mac_tx_clk_oe_n;
   logic tx_clk;
   // Transmit control, driven by the MAC
   logic mac_tx_ctl;
   // Shared open-drain power-down or interrupt pin
   logic phy_pd_o;
   logic phy_pd_oe_n;
   logic mac_pd_o;
   logic mac_pd_oe_n;
   logic pd_pin;

   // Wire resolution: pull-down on clocks, pull-up on the shared pin
   assign rx_clk = ~phy_rx_clk_oe_n & phy_rx_clk_o;
   assign tx_clk = (~phy_tx_clk_oe_n & phy_tx_clk_o) | (~mac_tx_clk_oe_n & mac_tx_clk_o);
   assign pd_pin = (phy_pd_oe_n | phy_pd_o) & (mac_pd_oe_n | mac_pd_o);

   modport phy (
      output phy_rx_clk_o, phy_rx_clk_oe_n, phy_rx_ctl, phy_rx_er,
      output phy_tx_clk_o, phy_tx_clk_oe_n, phy_pd_o, phy_pd_oe_n,
      input tx_clk, mac_tx_ctl, pd_pin
   );
   modport mac (
      output mac_tx_clk_o, mac_tx_clk_oe_n, mac_tx_ctl, mac_pd_o, mac_pd_oe_n,
      input rx_clk, phy_rx_ctl, phy_rx_er, tx_clk, pd_pin
   );
endinterface

/* File: hw/pmsp_sync.sv */
`timescale 1ns/1ps
module pmsp_sync #(
   parameter int W = 1,
   parameter logic [W-1:0] RST = '0
) (
   // Destination clock
   input wire logic clk,
   input wire logic arst_n,
   // Data
   input wire logic [W-1:0] d,
   output logic [W-1:0] q
);
   logic [W-1:0] meta_r;

   // Two stages; only the second one is read outside
   always_ff @(posedge clk or negedge arst_n) begin
      if (!arst_n) begin
         meta_r <= RST;
         q <= RST;
      end else begin
         meta_r <= d;
         q <= meta_r;
      end
   end
endmodule

/* File: hw/pmsp_phy_end.sv */
`timescale 1ns/1ps
`include "pmsp_map.svh"
module pmsp_phy_end import pmsp_pkg::*; #(
   parameter int DIV = `PMSP_LINK_DIV,
   parameter int HIGH = `PMSP_LINK_HIGH
) (
   // System clock and reset
   input wire logic ref_clk,
   input wire logic arst_n,
   // Link clock
   input wire logic link_clk,
   // Configuration from software
   input wire pmsp_mode_e cfg_mode,
   input wire logic irq_mode_set,
   // Events and receive status
   input wire logic irq_event,
   input wire logic irq_ack,
   input wire logic rx_dv_in,
   input wire logic rx_err_event,
   // Status towards the system
   output logic powerdown,
   output logic irq_pending,
   output logic tx_en_seen,
   output logic tx_er_seen,
   // MAC-side pins
   pmsp_link_if.phy lnk
);
   localparam logic [2:0] CNT_LAST = 3'(DIV - 1);
   localparam logic [2:0] CNT_HIGH = 3'(HIGH);

   typedef struct packed {
      logic [2:0] cnt;
      pmsp_mode_e mode_seen;
      pmsp_mode_e mode_act;
      logic rmii;
      logic rx_clk_pin;
      logic rx_clk_oe_n;
      logic tx_clk_pin;
      logic tx_clk_oe_n;
      logic rx_ctl;
      logic rx_er;
      logic err_seen;
      logic err_pend;
      logic tclk_prev;
      logic tx_en;
      logic tx_er;
   } pmsp_phy_lnk_s;

   typedef struct packed {
      pmsp_mode_e mode;
      logic err_tgl;
      logic irq_mode;
      logic irq_pend;
      logic pd_oe_n;
      logic powerdown;
      logic tx_en_seen;
      logic tx_er_seen;
   } pmsp_phy_ref_s;

   pmsp_phy_lnk_s l_r;
   pmsp_phy_lnk_s l_nxt;
   pmsp_phy_ref_s r_r;
   pmsp_phy_ref_s r_nxt;
   logic [5:0] ls;
   logic [2:0] rs;
   pmsp_mode_e mode_l;
   logic dv_l;
   logic err_l;
   logic tclk_l;
   logic tctl_l;
   logic ev;
   logic rise;
   logic fall;
   logic mii_clk;

   // Config, status and pin levels into the link domain
   pmsp_sync #(.W(6), .RST({4'h0, `PMSP_MODE_IDLE})) u_sync_lnk (
      .clk(link_clk),
      .arst_n(arst_n),
      .d({lnk.mac_tx_ctl, lnk.tx_clk, r_r.err_tgl, rx_dv_in, r_r.mode}),
      .q(ls)
   );

   // Pin and link levels into the system domain
   pmsp_sync #(.W(3), .RST({`PMSP_PD_IDLE, 2'h0})) u_sync_ref (
      .clk(ref_clk),
      .arst_n(arst_n),
      .d({lnk.pd_pin, l_r.tx_er, l_r.tx_en}),
      .q(rs)
   );

   assign mode_l = pmsp_mode_e'(ls[1:0]);
   assign dv_l = ls[2];
   assign err_l = ls[3];
   assign tclk_l = ls[4];
   assign tctl_l = ls[5];

   // Link-facing logic: clocks, receive signalling, transmit sampling
   always_comb begin
      l_nxt = l_r;
      // Mode bits cross apart, so act only on two equal samples
      l_nxt.mode_seen = mode_l;
      if (mode_l == l_r.mode_seen) begin
         l_nxt.mode_act = mode_l;
      end
      l_nxt.cnt = (l_r.cnt == CNT_LAST) ? 3'h0 : l_r.cnt + 3'h1;
      rise = (l_nxt.cnt == 3'h0);
      fall = (l_nxt.cnt == CNT_HIGH);
      mii_clk = (l_nxt.cnt < CNT_HIGH);
      l_nxt.rmii = ~l_r.rmii;
      l_nxt.tclk_prev = tclk_l;
      // Error toggles become events; a new one beats a clear
      ev = err_l ^ l_r.err_seen;
      l_nxt.err_seen = err_l;
      l_nxt.err_pend = l_r.err_pend | ev;
      unique case (l_nxt.mode_act)
         PMSP_MII: begin
            l_nxt.rx_clk_pin = mii_clk;
            l_nxt.rx_clk_oe_n = 1'b0;
            l_nxt.tx_clk_pin = mii_clk;
            l_nxt.tx_clk_oe_n = 1'b0;
            if (rise) begin
               l_nxt.rx_ctl = dv_l;
               l_nxt.rx_er = l_r.err_pend;
               l_nxt.err_pend = ev;
            end
            // Synced data lags two cycles, so this sees the rising edge
            if (l_r.cnt == CNT_HIGH) begin
               l_nxt.tx_en = tctl_l;
               l_nxt.tx_er = 1'b0;
            end
         end
         PMSP_RMII_MST, PMSP_RMII_SLV: begin
            l_nxt.rx_clk_pin = (l_nxt.mode_act == PMSP_RMII_MST) & l_nxt.rmii;
            l_nxt.rx_clk_oe_n = (l_nxt.mode_act == PMSP_RMII_SLV);
            l_nxt.tx_clk_pin = 1'b0;
            l_nxt.tx_clk_oe_n = 1'b1;
            if (l_nxt.rmii) begin
               l_nxt.rx_ctl = dv_l;
               l_nxt.rx_er = l_r.err_pend;
               l_nxt.err_pend = ev;
               l_nxt.tx_en = tctl_l;
               l_nxt.tx_er = 1'b0;
            end
         end
         PMSP_RGMII: begin
            l_nxt.rx_clk_pin = mii_clk;
            l_nxt.rx_clk_oe_n = 1'b0;
            l_nxt.tx_clk_pin = 1'b0;
            l_nxt.tx_clk_oe_n = 1'b1;
            l_nxt.rx_er = 1'b0;
            if (rise) begin
               l_nxt.rx_ctl = dv_l;
            end else if (fall) begin
               l_nxt.rx_ctl = l_r.err_pend;
               l_nxt.err_pend = ev;
            end
            // Clock and line share one synchroniser delay
            if (tclk_l & ~l_r.tclk_prev) begin
               l_nxt.tx_en = tctl_l;
            end
            if (~tclk_l & l_r.tclk_prev) begin
               l_nxt.tx_er = tctl_l;
            end
         end
      endcase
   end

   always_ff @(posedge link_clk or negedge arst_n) begin
      if (!arst_n) begin
         l_r <= '0;
         // Start in a mode that drives no clock pin until the real one settles
         l_r.mode_seen <= pmsp_mode_e'(`PMSP_MODE_IDLE);
         l_r.mode_act <= pmsp_mode_e'(`PMSP_MODE_IDLE);
         l_r.rx_clk_oe_n <= 1'b1;
         l_r.tx_clk_oe_n <= 1'b1;
      end else begin
         l_r <= l_nxt;
      end
   end

   // System side: shared pin, error toggle, status
   always_comb begin
      r_nxt = r_r;
      r_nxt.mode = cfg_mode;
      r_nxt.err_tgl = r_r.err_tgl ^ rx_err_event;
      // Only a write moves the pin to interrupt use
      r_nxt.irq_mode = r_r.irq_mode | irq_mode_set;
      // Event in the ack cycle keeps the flag set
      r_nxt.irq_pend = r_r.irq_mode & (irq_event | (r_r.irq_pend & ~irq_ack));
      r_nxt.pd_oe_n = ~r_nxt.irq_pend;
      r_nxt.powerdown = ~r_r.irq_mode & ~rs[2];
      r_nxt.tx_en_seen = rs[0];
      r_nxt.tx_er_seen = rs[1];
   end

   always_ff @(posedge ref_clk or negedge arst_n) begin
      if (!arst_n) begin
         r_r <= '0;
         r_r.mode <= pmsp_mode_e'(`PMSP_MODE_IDLE);
         r_r.pd_oe_n <= 1'b1;
      end else begin
         r_r <= r_nxt;
      end
   end

   // Outputs straight from the registers
   assign powerdown = r_r.powerdown;
   assign irq_pending = r_r.irq_pend;
   assign tx_en_seen = r_r.tx_en_seen;
   assign tx_er_seen = r_r.tx_er_seen;
   assign lnk.phy_rx_clk_o = l_r.rx_clk_pin;
   assign lnk.phy_rx_clk_oe_n = l_r.rx_clk_oe_n;
   assign lnk.phy_rx_ctl = l_r.rx_ctl;
   assign lnk.phy_rx_er = l_r.rx_er;
   assign lnk.phy_tx_clk_o = l_r.tx_clk_pin;
   assign lnk.phy_tx_clk_oe_n = l_r.tx_clk_oe_n;
   // Open drain: only ever drives low
   assign lnk.phy_pd_o = 1'b0;
   assign lnk.phy_pd_oe_n = r_r.pd_oe_n;
endmodule

/* File: hw/pmsp_mac_end.sv */
`timescale 1ns/1ps
`include "pmsp_map.svh"
module pmsp_mac_end import pmsp_pkg::*; #(
   parameter int HALF = `PMSP_MAC_HALF
) (
   // System clock and reset
   input wire logic ref_clk,
   input wire logic arst_n,
   // User requests
   input wire pmsp_mode_e cfg_mode,
   input wire logic tx_en_req,
   input wire logic tx_er_req,
   input wire logic pd_req,
   // Receive status
   output logic rx_dv_seen,
   output logic rx_er_seen,
   output logic irq_seen,
   // PHY-side pins
   pmsp_link_if.mac lnk
);
   localparam logic [3:0] CNT_LAST = 4'(2 * HALF - 1);
   localparam logic [3:0] CNT_HIGH = 4'(HALF);
   localparam logic [3:0] EN_AT = 4'(`PMSP_MAC_EN_AT);
   localparam logic [3:0] ER_AT = 4'(`PMSP_MAC_ER_AT);

   typedef struct packed {
      logic [3:0] cnt;
      logic tx_clk;
      logic tx_clk_oe_n;
      logic tx_ctl;
      logic pd_oe_n;
      logic tclk_prev;
      logic rclk_prev;
      logic rx_dv;
      logic rx_er;
      logic irq_seen;
   } pmsp_mac_s;

   pmsp_mac_s s_r;
   pmsp_mac_s s_nxt;
   logic [4:0] ps;
   logic tclk_s;
   logic rclk_s;

   // Pins from the PHY into this clock domain
   pmsp_sync #(.W(5), .RST({`PMSP_PD_IDLE, 4'h0})) u_sync_pin (
      .clk(ref_clk),
      .arst_n(arst_n),
      .d({lnk.pd_pin, lnk.phy_rx_er, lnk.phy_rx_ctl, lnk.rx_clk, lnk.tx_clk}),
      .q(ps)
   );

   assign tclk_s = ps[0];
   assign rclk_s = ps[1];

   // Transmit clock and control, receive capture, shared pin
   always_comb begin
      s_nxt = s_r;
      s_nxt.cnt = (s_r.cnt == CNT_LAST) ? 4'h0 : s_r.cnt + 4'h1;
      s_nxt.tclk_prev = tclk_s;
      s_nxt.rclk_prev = rclk_s;
      s_nxt.tx_clk = (cfg_mode == PMSP_RGMII) & (s_nxt.cnt < CNT_HIGH);
      s_nxt.tx_clk_oe_n = (cfg_mode != PMSP_RGMII);
      unique case (cfg_mode)
         PMSP_MII: begin
            // Change on the fall so the line is steady at the rise
            if (s_r.tclk_prev & ~tclk_s) begin
               s_nxt.tx_ctl = tx_en_req;
            end
         end
         PMSP_RMII_MST, PMSP_RMII_SLV: begin
            s_nxt.tx_ctl = tx_en_req;
         end
         PMSP_RGMII: begin
            if (s_nxt.cnt == EN_AT) begin
               s_nxt.tx_ctl = tx_en_req;
            end else if (s_nxt.cnt == ER_AT) begin
               s_nxt.tx_ctl = tx_er_req;
            end
         end
      endcase
      if (rclk_s & ~s_r.rclk_prev) begin
         s_nxt.rx_dv = ps[2];
         if (cfg_mode != PMSP_RGMII) begin
            s_nxt.rx_er = ps[3];
         end
      end
      if (~rclk_s & s_r.rclk_prev & (cfg_mode == PMSP_RGMII)) begin
         s_nxt.rx_er = ps[2];
      end
      s_nxt.pd_oe_n = ~pd_req;
      s_nxt.irq_seen = ~ps[4] & ~pd_req;
   end

   always_ff @(posedge ref_clk or negedge arst_n) begin
      if (!arst_n) begin
         s_r <= '0;
         // Wrap on the first edge so the first high phase is whole
         s_r.cnt <= CNT_LAST;
         s_r.tx_clk_oe_n <= 1'b1;
         s_r.pd_oe_n <= 1'b1;
      end else begin
         s_r <= s_nxt;
      end
   end

   assign rx_dv_seen = s_r.rx_dv;
   assign rx_er_seen = s_r.rx_er;
   assign irq_seen = s_r.irq_seen;
   assign lnk.mac_tx_clk_o = s_r.tx_clk;
   assign lnk.mac_tx_clk_oe_n = s_r.tx_clk_oe_n;
   assign lnk.mac_tx_ctl = s_r.tx_ctl;
   assign lnk.mac_pd_o = 1'b0;
   assign lnk.mac_pd_oe_n = s_r.pd_oe_n;
endmodule

/* File: testbench/pmsp_properties.sv */
`timescale 1ns/1ps
module pmsp_properties import pmsp_pkg::*; (
   // Clocks, reset and mode
   input wire logic ref_clk,
   input wire logic link_clk,
   input wire logic arst_n,
   input wire pmsp_mode_e cfg_mode,
   // Link pins
   input wire logic rx_clk,
   input wire logic phy_rx_clk_oe_n,
   input wire logic phy_rx_ctl,
   input wire logic phy_rx_er,
   input wire logic tx_clk,
   input wire logic phy_tx_clk_oe_n,
   input wire logic mac_tx_ctl,
   input wire logic phy_pd_o,
   input wire logic phy_pd_oe_n,
   input wire logic pd_pin
);
   // Slow clock modes; shapes assume the default dividers
   wire logic slow_mode = (cfg_mode == PMSP_MII) || (cfg_mode == PMSP_RGMII);

   AST_RX_CLK_SHAPE: assert property (@(posedge link_clk) disable iff (!arst_n)
      slow_mode && $rose(rx_clk) |-> rx_clk [*2] ##1 !rx_clk [*3] ##1 rx_clk)
      else $error("receive clock shape wrong");
   AST_RMII_REF_CLK: assert property (@(posedge link_clk) disable iff (!arst_n)
      cfg_mode == PMSP_RMII_MST && $rose(rx_clk) |=> !rx_clk ##1 rx_clk)
      else $error("reference clock not toggling");
   AST_SLAVE_RX_CLK_FREE: assert property (@(posedge ref_clk) disable iff (!arst_n)
      cfg_mode == PMSP_RMII_SLV |-> phy_rx_clk_oe_n)
      else $error("receive clock driven in slave mode");
   AST_RX_ER_AT_RISE: assert property (@(posedge link_clk) disable iff (!arst_n)
      cfg_mode inside {PMSP_MII, PMSP_RMII_MST} && $changed(phy_rx_er) |-> $rose(rx_clk))
      else $error("receive error moved off clock rise");
   AST_RX_CTL_AT_EDGE: assert property (@(posedge link_clk) disable iff (!arst_n)
      cfg_mode == PMSP_RGMII && $changed(phy_rx_ctl) |-> $changed(rx_clk))
      else $error("receive control moved off clock edge");
   AST_PD_OPEN_DRAIN: assert property (@(posedge ref_clk) disable iff (!arst_n)
      !phy_pd_oe_n |-> !phy_pd_o && !pd_pin)
      else $error("shared pin driven high");
   AST_MII_TX_CLK_SHAPE: assert property (@(posedge link_clk) disable iff (!arst_n)
      cfg_mode == PMSP_MII && $rose(tx_clk) |-> tx_clk [*2] ##1 !tx_clk [*3] ##1 tx_clk)
      else $error("transmit clock shape wrong");
   AST_RGMII_PHY_TX_CLK_OFF: assert property (@(posedge ref_clk) disable iff (!arst_n)
      cfg_mode == PMSP_RGMII |-> phy_tx_clk_oe_n)
      else $error("device drives transmit clock");
   AST_RGMII_MAC_TX_CLK: assert property (@(posedge ref_clk) disable iff (!arst_n)
      cfg_mode == PMSP_RGMII && $rose(tx_clk) |-> tx_clk [*8] ##1 !tx_clk [*8] ##1 tx_clk)
      else $error("MAC transmit clock shape wrong");
   AST_TX_CTL_MID_PHASE: assert property (@(posedge ref_clk) disable iff (!arst_n)
      cfg_mode == PMSP_RGMII && $changed(mac_tx_ctl) |-> $stable(tx_clk) ##1 $stable(tx_clk))
      else $error("transmit control moved near clock edge");

   // Main scenarios reached
   cover property (@(posedge link_clk) disable iff (!arst_n) $rose(phy_rx_er));
   cover property (@(posedge ref_clk) disable iff (!arst_n) $rose(mac_tx_ctl));
   cover property (@(posedge ref_clk) disable iff (!arst_n) !phy_pd_oe_n);
endmodule

/* File: testbench/phy_mac_side_pin_behaviour_test.sv */
`timescale 1ns/1ps
module phy_mac_side_pin_behaviour_test import pmsp_pkg::*;;
   // Clocks, reset and stimulus
   logic ref_clk = 1'h0;
   logic link_clk = 1'h0;
   logic arst_n = 1'h0;
   pmsp_mode_e cfg_mode = PMSP_MII;
   logic irq_mode_set = 1'h0, irq_event = 1'h0, irq_ack = 1'h0, rx_dv_in = 1'h0;
   logic rx_err_event = 1'h0, tx_en_req = 1'h0, tx_er_req = 1'h0, pd_req = 1'h0;
   // Observed results
   logic powerdown, irq_pending, tx_en_seen, tx_er_seen, rx_dv_seen, rx_er_seen, irq_seen;
   logic [7:0] obs;
   int failures = 0;
   int samples_checked = 0;
   pmsp_link_if lnk ();

   // Bit order: pin, rx valid, rx error, irq seen, powerdown, pending, tx enable, tx error
   assign obs = {lnk.pd_pin, rx_dv_seen, rx_er_seen, irq_seen, powerdown, irq_pending, tx_en_seen, tx_er_seen};

   // System clock
   initial begin
      forever #12.5 ref_clk = ~ref_clk;
   end
   // Link clock, offset so its edges never meet a system edge
   initial begin
      #7;
      forever #40 link_clk = ~link_clk;
   end

   pmsp_phy_end pmsp_phy_end_inst (.ref_clk(ref_clk), .arst_n(arst_n), .link_clk(link_clk),
      .cfg_mode(cfg_mode), .irq_mode_set(irq_mode_set), .irq_event(irq_event), .irq_ack(irq_ack),
      .rx_dv_in(rx_dv_in), .rx_err_event(rx_err_event), .powerdown(powerdown),
      .irq_pending(irq_pending), .tx_en_seen(tx_en_seen), .tx_er_seen(tx_er_seen), .lnk(lnk.phy));
   pmsp_mac_end pmsp_mac_end_inst (.ref_clk(ref_clk), .arst_n(arst_n), .cfg_mode(cfg_mode),
      .tx_en_req(tx_en_req), .tx_er_req(tx_er_req), .pd_req(pd_req), .rx_dv_seen(rx_dv_seen),
      .rx_er_seen(rx_er_seen), .irq_seen(irq_seen), .lnk(lnk.mac));
   pmsp_properties pmsp_properties_inst (.ref_clk(ref_clk), .link_clk(link_clk), .arst_n(arst_n),
      .cfg_mode(cfg_mode), .rx_clk(lnk.rx_clk), .phy_rx_clk_oe_n(lnk.phy_rx_clk_oe_n),
      .phy_rx_ctl(lnk.phy_rx_ctl), .phy_rx_er(lnk.phy_rx_er), .tx_clk(lnk.tx_clk),
      .phy_tx_clk_oe_n(lnk.phy_tx_clk_oe_n), .mac_tx_ctl(lnk.mac_tx_ctl), .phy_pd_o(lnk.phy_pd_o),
      .phy_pd_oe_n(lnk.phy_pd_oe_n), .pd_pin(lnk.pd_pin));

   // Verdict and end of run
   task automatic complete_run();
      if (failures == 0 && samples_checked > 0) begin
         $display("All checks passed");
      end else begin
         $display("Checks failed");
      end
      $finish;
   endtask
   // Inputs always change 2 ns after a system edge
   task automatic step(input int n);
      repeat (n) @(posedge ref_clk);
      #2;
   endtask
   // One bit comparison
   task automatic check(input string name, input logic seen, input logic exp);
      samples_checked++;
      if (seen !== exp) begin
         failures++;
         $display("BAD %s expected %b seen %b", name, exp, seen);
      end
   endtask
   // Bounded wait on one observed bit; running out ends the run
   task automatic wait_obs(input int idx, input logic exp, input string name);
      int i;
      for (i = 0; i < 80 && obs[idx] !== exp; i++) step(1);
      check(name, obs[idx], exp);
      if (obs[idx] !== exp) complete_run();
   endtask
   // Reset with a new mode; mode is static outside reset
   task automatic restart(input pmsp_mode_e m);
      arst_n = 1'h0;
      cfg_mode = m;
      step(12);
      arst_n = 1'h1;
      step(4);
   endtask
   // One reception error, seen and then cleared at the MAC
   task automatic rx_error();
      rx_err_event = 1'h1;
      step(1);
      rx_err_event = 1'h0;
      wait_obs(5, 1'h1, "rx_er_seen");
      wait_obs(5, 1'h0, "rx_er_seen");
   endtask

   // Main sequence
   initial begin
      pmsp_mode_e m;
      restart(PMSP_MII);
      irq_event = 1'h1;
      step(1);
      irq_event = 1'h0;
      step(4);
      check("irq_pending", irq_pending, 1'h0);
      check("pd_pin", lnk.pd_pin, 1'h1);
      pd_req = 1'h1;
      wait_obs(3, 1'h1, "powerdown");
      pd_req = 1'h0;
      wait_obs(3, 1'h0, "powerdown");
      irq_mode_set = 1'h1;
      step(1);
      irq_mode_set = 1'h0;
      irq_event = 1'h1;
      step(1);
      irq_event = 1'h0;
      check("irq_pending", irq_pending, 1'h1);
      check("pd_pin", lnk.pd_pin, 1'h0);
      wait_obs(4, 1'h1, "irq_seen");
      check("powerdown", powerdown, 1'h0);
      // Acknowledge and a new event together: the event wins
      irq_ack = 1'h1;
      irq_event = 1'h1;
      step(1);
      irq_event = 1'h0;
      check("irq_pending", irq_pending, 1'h1);
      step(1);
      irq_ack = 1'h0;
      check("irq_pending", irq_pending, 1'h0);
      wait_obs(7, 1'h1, "pd_pin");
      // Every mode: transmit control, then receive status in all but RMII slave
      for (int k = 0; k < 4; k++) begin
         m = pmsp_mode_e'(2'(k));
         restart(m);
         tx_en_req = 1'h1;
         wait_obs(1, 1'h1, "tx_en_seen");
         tx_en_req = 1'h0;
         tx_er_req = 1'h1;
         wait_obs(1, 1'h0, "tx_en_seen");
         step(40);
         check("tx_er_seen", tx_er_seen, m == PMSP_RGMII);
         tx_er_req = 1'h0;
         check("rx_clk_oe_n", lnk.phy_rx_clk_oe_n, m == PMSP_RMII_SLV);
         if (m != PMSP_RMII_SLV) begin
            rx_dv_in = 1'h1;
            wait_obs(6, 1'h1, "rx_dv_seen");
            check("rx_er_seen", rx_er_seen, 1'h0);
            rx_error();
            rx_dv_in = 1'h0;
            wait_obs(6, 1'h0, "rx_dv_seen");
            rx_error();
         end
      end
      complete_run();
   end
endmodule
